// *** hw/slgd_defines.svh ***
// Field positions, reset values and counts of the LED gray driver
`ifndef SLGD_DEFINES_SVH
`define SLGD_DEFINES_SVH
`define SLGD_CMD_RESET 16'h0000
`define SLGD_GAIN_LSB 0
`define SLGD_GAIN_MSB 7
`define SLGD_REFRESH_BIT 8
`define SLGD_GHOST_BIT 9
`define SLGD_MODE_LSB 10
`define SLGD_MODE_MSB 11
`define SLGD_START_PULSES 3'h4
`define SLGD_CHANNELS 16
`define SLGD_GRAY_BITS 16
`define SLGD_LINE_BITS 256
`define SLGD_LINES 8
`define SLGD_EDGES_PER_CLK 2
`define SLGD_SEG_CLK_LOW 512
`define SLGD_SEG_CLK_HIGH 128
`define SLGD_SEGS_LOW 64
`define SLGD_SEGS_HIGH 256
`define SLGD_BUF_DEPTH 2
`endif

// *** hw/slgd_pkg.sv ***
// Types shared by the LED gray driver files
package slgd_pkg;
    typedef enum logic [1:0] {
        SLGD_WAIT = 2'b00,
        SLGD_CMD = 2'b01,
        SLGD_SCAN = 2'b10
    } slgd_phase_t;
    typedef enum logic [1:0] {
        SLGD_EV_START = 2'b00,
        SLGD_EV_CMD = 2'b01,
        SLGD_EV_SCAN = 2'b10
    } slgd_kind_t;
    typedef struct packed {
        logic [3:0] reserved;
        logic [1:0] scanMode;
        logic ghost;
        logic refreshHigh;
        logic [7:0] gain_code;
    } slgd_cmd_t;
    typedef struct packed {
        slgd_kind_t kind;
        logic [2:0] idx;
        logic [255:0] word;
    } slgd_evt_t;
    typedef struct packed {
        logic [15:0] on;
        logic [15:0] pull;
    } slgd_drive_t;
endpackage

// *** hw/slgd_sync.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ns
module slgd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } slgd_sync_t;
    slgd_sync_t s, next_s;
    always_comb begin
        next_s.meta = d;
        next_s.q = s.meta;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign q = s.q;
endmodule // slgd_sync

// *** hw/slgd_fifo.sv ***
// Small valid/ready buffer
`timescale 1ns/1ns
module slgd_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0] count;
    } slgd_fifo_t;
    slgd_fifo_t s, next_s;
    logic push, pop;
    assign inReady = (s.count != (PW+1)'(DEPTH));
    assign outValid = (s.count != '0);
    assign outData = s.mem[s.rdPtr];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wrPtr] = inData;
            next_s.wrPtr = (s.wrPtr == PW'(DEPTH-1)) ? '0 : PW'(s.wrPtr + 1'b1);
        end
        if (pop) begin
            next_s.rdPtr = (s.rdPtr == PW'(DEPTH-1)) ? '0 : PW'(s.rdPtr + 1'b1);
        end
        next_s.count = (PW+1)'(s.count + push - pop);
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_fifo_full_stall: assert property (!inReady && !pop |=> s.count == (PW+1)'(DEPTH))
        else $error("buffer left full state without a pop");
    c_fifo_full: cover property (!inReady);
endmodule // slgd_fifo

// *** hw/slgd_top.sv ***
// Scanned LED gray driver control logic
`timescale 1ns/1ns
`include "slgd_defines.svh"
module slgd_top (
    // Clocks and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serial_shift_clock,
    // Serial link
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic gray_clock,
    output logic serial_out,
    // Channel drive
    output slgd_pkg::slgd_drive_t channelDrive,
    output logic [7:0] gain_code,
    output logic [2:0] activeLine
);
    import slgd_pkg::*;

    localparam int EW = $bits(slgd_evt_t);

    typedef struct packed {
        logic [255:0] chain;
        logic [7:0] hiTot;
    } slgd_link_t;

    typedef struct packed {
        slgd_phase_t phase;
        logic [2:0] scanIdx;
        logic [1:0] pushMode;
        logic evPend;
        slgd_evt_t evData;
        slgd_cmd_t cmd;
        logic [`SLGD_LINES-1:0][`SLGD_LINE_BITS-1:0] mem;
        logic latchPrev;
        logic grayPrev;
        logic [7:0] hiBase;
        logic [9:0] pos;
        logic [7:0] seg;
        logic [2:0] line;
        logic blank;
        logic blankEdge;
        slgd_drive_t drive;
    } slgd_state_t;

    slgd_link_t l, next_l;
    slgd_state_t s, next_s;
    logic latchQ, grayQ, latchFall, grayEdge;
    logic bufReady, deqValid, deq;
    slgd_evt_t deqEv;
    logic [15:0] step;
    logic [15:0] chanOn;
    logic [9:0] posLast;
    logic [7:0] segLast;
    logic [7:0] hiDiff;
    logic startSeen;

    function automatic logic [2:0] last_line(input logic [1:0] mode);
        unique case (mode)
            2'h1: last_line = 3'h1;
            2'h2: last_line = 3'h3;
            2'h3: last_line = 3'h7;
            default: last_line = 3'h0;
        endcase
    endfunction

    function automatic logic [15:0] bit_rev(input logic [15:0] v);
        bit_rev = '0;
        for (int i = 0; i < 16; i++) begin
            bit_rev[i] = v[15-i];
        end
    endfunction

    always_comb begin
        next_l = l;
        if (latch_strobe) begin
            // Running total, back-to-back latches give no clearing edge
            next_l.hiTot = 8'(l.hiTot + 1'b1);
        end else begin
            next_l.chain = {l.chain[254:0], serial_in};
        end
    end

    always_ff @(posedge serial_shift_clock or negedge reset_n) begin
        if (!reset_n) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    slgd_sync #(.W(2)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d({latch_strobe, gray_clock}),
        .q({latchQ, grayQ})
    );

    assign latchFall = s.latchPrev & ~latchQ;
    assign grayEdge = grayQ ^ s.grayPrev;
    assign hiDiff = 8'(l.hiTot - s.hiBase);
    assign startSeen = (hiDiff == 8'(`SLGD_START_PULSES));

    slgd_fifo #(.W(EW), .DEPTH(`SLGD_BUF_DEPTH)) u_buf (
        .clk(clk),
        .reset_n(reset_n),
        .inValid(s.evPend),
        .inReady(bufReady),
        .inData(s.evData),
        .outValid(deqValid),
        .outReady(~s.blank),
        .outData(deqEv)
    );
    assign deq = deqValid & ~s.blank;

    assign posLast = s.cmd.refreshHigh
        ? 10'(`SLGD_SEG_CLK_HIGH * `SLGD_EDGES_PER_CLK - 1)
        : 10'(`SLGD_SEG_CLK_LOW * `SLGD_EDGES_PER_CLK - 1);
    assign segLast = s.cmd.refreshHigh ? 8'(`SLGD_SEGS_HIGH - 1) : 8'(`SLGD_SEGS_LOW - 1);
    assign step = s.cmd.refreshHigh ? {s.seg, s.pos[7:0]} : {s.seg[5:0], s.pos};

    genvar c;
    generate
        for (c = 0; c < `SLGD_CHANNELS; c++) begin : g_chan
            assign chanOn[c] = bit_rev(step) <
                s.mem[s.line][c*`SLGD_GRAY_BITS +: `SLGD_GRAY_BITS];
        end
    endgenerate

    always_comb begin
        next_s = s;
        next_s.latchPrev = latchQ;
        next_s.grayPrev = grayQ;
        if (s.evPend && bufReady) begin
            next_s.evPend = 1'b0;
        end
        if (latchFall) begin
            next_s.hiBase = l.hiTot;
            if (startSeen) begin
                next_s.evPend = 1'b1;
                next_s.evData = '{SLGD_EV_START, 3'h0, l.chain};
                next_s.phase = SLGD_CMD;
            end else begin
                unique case (s.phase)
                    SLGD_CMD: begin
                        next_s.evPend = 1'b1;
                        next_s.evData = '{SLGD_EV_CMD, 3'h0, l.chain};
                        next_s.pushMode = l.chain[`SLGD_MODE_MSB:`SLGD_MODE_LSB];
                        next_s.scanIdx = 3'h0;
                        next_s.phase = SLGD_SCAN;
                    end
                    SLGD_SCAN: begin
                        next_s.evPend = 1'b1;
                        next_s.evData = '{SLGD_EV_SCAN, s.scanIdx, l.chain};
                        next_s.scanIdx = 3'(s.scanIdx + 1'b1);
                        if (s.scanIdx >= last_line(s.pushMode)) begin
                            next_s.phase = SLGD_WAIT;
                        end
                    end
                    SLGD_WAIT: begin
                        next_s.phase = SLGD_WAIT;
                    end
                    default: begin
                        next_s.phase = SLGD_WAIT;
                    end
                endcase
            end
        end
        if (grayEdge) begin
            if (s.blank) begin
                if (s.blankEdge) begin
                    next_s.blank = 1'b0;
                    next_s.blankEdge = 1'b0;
                    if (s.line >= last_line(s.cmd.scanMode)) begin
                        next_s.line = 3'h0;
                        next_s.seg = (s.seg >= segLast) ? 8'h00 : 8'(s.seg + 1'b1);
                    end else begin
                        next_s.line = 3'(s.line + 1'b1);
                    end
                end else begin
                    next_s.blankEdge = 1'b1;
                end
            end else if (s.pos >= posLast) begin
                next_s.pos = 10'h000;
                next_s.blank = 1'b1;
                next_s.blankEdge = 1'b0;
            end else begin
                next_s.pos = 10'(s.pos + 1'b1);
            end
        end
        if (deq) begin
            unique case (deqEv.kind)
                SLGD_EV_START: begin
                    next_s.pos = 10'h000;
                    next_s.seg = 8'h00;
                    next_s.line = 3'h0;
                    next_s.blank = 1'b0;
                    next_s.blankEdge = 1'b0;
                end
                SLGD_EV_CMD: begin
                    next_s.cmd = deqEv.word[15:0];
                    next_s.cmd.reserved = 4'h0;
                end
                SLGD_EV_SCAN: begin
                    next_s.mem[deqEv.idx] = deqEv.word;
                end
                default: begin
                    next_s.cmd = s.cmd;
                end
            endcase
        end
        next_s.drive.on = s.blank ? 16'h0000 : chanOn;
        next_s.drive.pull = s.cmd.ghost ? ~next_s.drive.on : 16'h0000;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign serial_out = l.chain[255];
    assign channelDrive = s.drive;
    assign gain_code = s.cmd.gain_code;
    assign activeLine = s.line;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_start_seen: assert property (
        latchFall && startSeen |=> s.evPend && s.evData.kind == SLGD_EV_START)
        else $error("start instruction not recognised");
    a_start_clears: assert property (
        deq && deqEv.kind == SLGD_EV_START |=> s.pos == 10'h000 && s.line == 3'h0 && !s.blank)
        else $error("start did not clear gray counter");
    a_cmd_loads: assert property (
        deq && deqEv.kind == SLGD_EV_CMD
        |=> s.cmd[11:0] == $past(deqEv.word[11:0]) && s.cmd.reserved == 4'h0)
        else $error("command word not loaded");
    a_scan_next: assert property (
        latchFall && s.phase == SLGD_SCAN && !startSeen
        |=> s.scanIdx == 3'($past(s.scanIdx) + 1'b1))
        else $error("scan line index did not advance");
    a_other_count: assert property (
        latchFall && !startSeen && s.phase == SLGD_WAIT |=> !s.evPend)
        else $error("stray latch produced an event");
    a_both_edges: assert property (
        grayEdge && !s.blank && s.pos < posLast && !deq |=> s.pos == 10'($past(s.pos) + 1'b1))
        else $error("gray counter missed an edge");
    a_seg_end: assert property (
        grayEdge && !s.blank && s.pos >= posLast && !deq |=> s.blank && s.pos == 10'h000)
        else $error("segment end did not start blanking");
    a_blank_off: assert property (
        s.blank |=> s.drive.on == 16'h0000)
        else $error("outputs on during blanking");
    a_blank_short: assert property (
        s.blank && s.blankEdge && grayEdge |=> !s.blank)
        else $error("blanking exceeded one gray clock");
    a_pull_off: assert property (
        (s.drive.pull & s.drive.on) == 16'h0000)
        else $error("pull up on a driving output");
    a_ghost_blank: assert property (
        s.cmd.ghost && s.blank ##1 s.cmd.ghost |-> s.drive.pull == 16'hffff)
        else $error("no pull up during blanking");

    c_start: cover property (deq && deqEv.kind == SLGD_EV_START);
    c_cmd: cover property (deq && deqEv.kind == SLGD_EV_CMD);
    c_scan_last: cover property (deq && deqEv.kind == SLGD_EV_SCAN && deqEv.idx == 3'h7);
    c_blank: cover property ($rose(s.blank));
endmodule // slgd_top

// *** bench/slgd_ctrl_model.sv ***
// Display controller model driving the serial link and the gray clock
`timescale 1ns/1ns
module slgd_ctrl_model (
    // Pacing clock for the gray clock
    input wire logic clk,
    // Link and gray clock drive
    output logic serial_shift_clock,
    output logic serial_in,
    output logic latch_strobe,
    output logic gray_clock
);
    initial begin
        serial_shift_clock = 1'b0;
        serial_in = 1'b1;
        latch_strobe = 1'b0;
        gray_clock = 1'b0;
    end

    // One shift pulse, 80 ns period
    task automatic pulse();
        #20 serial_shift_clock = 1'b1;
        #40 serial_shift_clock = 1'b0;
        #20;
    endtask

    // One data bit, line shows inverse once hold time is over
    task automatic shift_bit(input logic b);
        serial_in = b;
        #20 serial_shift_clock = 1'b1;
        #40 serial_shift_clock = 1'b0;
        #5 serial_in = ~b;
        #15;
    endtask

    task automatic latch(input int n);
        #3 latch_strobe = 1'b1;
        #20;
        repeat (n) pulse();
        #40 latch_strobe = 1'b0;
        #40;
    endtask

    // start is four pulses under latch
    task automatic start();
        latch(4);
    endtask

    task automatic send_word(input logic [15:0] w);
        #3;
        for (int i = 15; i >= 0; i--) begin
            shift_bit(w[i]);
        end
    endtask

    // line data, channel fifteen top bit first
    task automatic send_line(input logic [255:0] v);
        for (int i = 255; i >= 0; i--) begin
            shift_bit(v[i]);
        end
    endtask

    // Gray clock edges, half period four system clocks
    task automatic gray_edges(input int n);
        repeat (n) begin
            repeat (4) @(negedge clk);
            gray_clock = ~gray_clock;
        end
    endtask
endmodule // slgd_ctrl_model

// *** bench/tb_top.sv ***
// Self-checking bench for the scanned LED gray driver
`timescale 1ns/1ns
module tb_top;
    import slgd_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic serial_shift_clock;
    logic serial_in;
    logic latch_strobe;
    logic gray_clock;
    logic serial_out;
    slgd_drive_t channelDrive;
    logic [7:0] gain_code;
    logic [2:0] activeLine;
    int n_mismatch = 0;
    int n_compared = 0;
    logic armed = 1'b0;
    logic [31:0] rngState = 32'h78fd;
    logic [7:0] lastGain = 8'h00;
    logic [7:0] gainQ[$];
    logic [34:0] lineQ[$];

    always #2 clk = ~clk;

    slgd_top slgd_top_inst (
        .clk(clk),
        .reset_n(reset_n),
        .serial_shift_clock(serial_shift_clock),
        .serial_in(serial_in),
        .latch_strobe(latch_strobe),
        .gray_clock(gray_clock),
        .serial_out(serial_out),
        .channelDrive(channelDrive),
        .gain_code(gain_code),
        .activeLine(activeLine)
    );

    slgd_ctrl_model slgd_ctrl_model_inst (
        .clk(clk),
        .serial_shift_clock(serial_shift_clock),
        .serial_in(serial_in),
        .latch_strobe(latch_strobe),
        .gray_clock(gray_clock)
    );

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    function automatic logic [15:0] lineOn(input int k);
        return (16'h0001 << k) | (16'h8000 >> k);
    endfunction

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Gain watcher
    always @(gain_code) begin
        if (armed) begin
            @(negedge clk);
            check("gain_code", gain_code, (gainQ.size() > 0) ? gainQ.pop_front() : 64'hx);
        end
    end

    // Line switch watcher
    always @(activeLine) begin
        if (armed) begin
            repeat (24) @(negedge clk);
            check("line switch", {activeLine, channelDrive},
                  (lineQ.size() > 0) ? lineQ.pop_front() : 64'hx);
        end
    end

    task automatic run_frame(input logic [1:0] mode, input logic refreshHigh, input int cmdPulses);
        logic [15:0] cmd;
        logic [255:0] ln;
        logic [15:0] on;
        logic ghost;
        int lines;
        int segClk;
        rngState = xorshift(rngState);
        ghost = rngState[20];
        cmd = {rngState[15:12], mode, ghost, refreshHigh, rngState[7:0]};
        if (cmd[7:0] == lastGain) begin
            cmd[7:0] = ~cmd[7:0];
        end
        lastGain = cmd[7:0];
        lines = 1 << mode;
        segClk = refreshHigh ? 128 : 512;
        slgd_ctrl_model_inst.start();
        slgd_ctrl_model_inst.send_word(cmd);
        gainQ.push_back(cmd[7:0]);
        slgd_ctrl_model_inst.latch(cmdPulses);
        for (int k = 0; k < lines; k++) begin
            ln = 256'h0;
            ln[k*16 +: 16] = 16'hffff;
            ln[(15-k)*16 +: 16] = 16'hffff;
            slgd_ctrl_model_inst.send_line(ln);
            slgd_ctrl_model_inst.latch(0);
            check("serial_out", serial_out, ln[255]);
        end
        for (int k = 1; k <= lines; k++) begin
            on = lineOn(k % lines);
            lineQ.push_back({3'(k % lines), on, ghost ? ~on : 16'h0000});
        end
        // start to show the loaded frame
        slgd_ctrl_model_inst.start();
        repeat (10) @(negedge clk);
        for (int k = 0; k < lines; k++) begin
            on = lineOn(k);
            slgd_ctrl_model_inst.gray_edges(segClk);
            repeat (8) @(negedge clk);
            check("mid drive", {activeLine, channelDrive},
                  {3'(k), on, ghost ? ~on : 16'h0000});
            slgd_ctrl_model_inst.gray_edges(segClk + 1);
            repeat (8) @(negedge clk);
            check("blank drive", channelDrive,
                  {16'h0000, ghost ? 16'hffff : 16'h0000});
            slgd_ctrl_model_inst.gray_edges(1);
        end
        repeat (40) @(negedge clk);
    endtask

    // Watchdog
    initial begin
        #400000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        check("reset state", {serial_out, gain_code, activeLine, channelDrive}, 64'h0);
        slgd_ctrl_model_inst.send_word(16'h00ff);
        slgd_ctrl_model_inst.latch(0);
        repeat (10) @(negedge clk);
        check("gain before start", gain_code, 64'h0);
        armed = 1'b1;
        run_frame(2'b01, 1'b0, 5);
        run_frame(2'b10, 1'b1, 0);
        run_frame(2'b11, 1'b1, 0);
        check("notes left", gainQ.size() + lineQ.size(), 64'h0);
        finish_test();
    end
endmodule // tb_top
